// file: rtl/esr_pkg.sv
package esr_pkg;
  localparam int unsigned ESR_FC_W = 8;
  localparam int unsigned ESR_ADDR_W = 16;
  localparam int unsigned ESR_QTY_W = 16;
  localparam int unsigned ESR_WORD_W = 32;
  localparam int unsigned ESR_REG_W = 16;
  // Function codes
  localparam logic [7:0] ESR_FC_READ_HOLD = 8'h03;
  localparam logic [7:0] ESR_FC_READ_INPUT = 8'h04;
  localparam logic [7:0] ESR_FC_EXC_FLAG = 8'h80;
  // Exception codes
  localparam logic [7:0] ESR_EX_NONE = 8'h00;
  localparam logic [7:0] ESR_EX_ILL_FUNC = 8'h01;
  localparam logic [7:0] ESR_EX_ILL_ADDR = 8'h02;
  localparam logic [7:0] ESR_EX_ILL_VALUE = 8'h03;
  localparam logic [7:0] ESR_EX_DEV_FAIL = 8'h04;
  localparam logic [7:0] ESR_EX_ACK = 8'h05;
  localparam logic [7:0] ESR_EX_BUSY = 8'h06;
  // Register map (register indices)
  localparam logic [15:0] ESR_INPUT_STATE_IDX = 16'h0004;
  localparam logic [15:0] ESR_INPUT_LAST = 16'h0005;
  localparam logic [15:0] ESR_HOLD_STATE_IDX = 16'h0062;
  localparam logic [15:0] ESR_HOLD_LAST = 16'h0063;
  localparam logic [15:0] ESR_QTY_MIN = 16'h0001;
  localparam logic [15:0] ESR_QTY_MAX = 16'h007D;
  // Status word field positions
  localparam int unsigned ESR_BIT_SCALE = 0;
  localparam int unsigned ESR_BIT_DIR = 1;
  localparam int unsigned ESR_BIT_ALARM = 8;
  localparam logic [31:0] ESR_STATE_RESET = 32'h0000_0000;
endpackage

// file: rtl/esr_state_word.sv
`timescale 1ns/10ps
`default_nettype none
module esr_state_word
  import esr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scale_en_in,
  input wire logic shaft_turn_left_in,
  input wire logic alarm_any_in,
  output logic [31:0] state_word_out
);
  typedef struct packed {
    logic [31:0] word;
  } esr_sw_s;

  esr_sw_s state_reg;
  esr_sw_s state_next;

  always_comb
  begin
    state_next = '0;
    state_next.word[ESR_BIT_SCALE] = scale_en_in;
    state_next.word[ESR_BIT_DIR] = shaft_turn_left_in;
    state_next.word[ESR_BIT_ALARM] = alarm_any_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      state_reg <= '{word: ESR_STATE_RESET};
    else
      state_reg <= state_next;
  end

  assign state_word_out = state_reg.word;

  a_unused_bits_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_word_out & ~32'h0000_0103) == 32'h0000_0000)
    else $error("unused status bits not zero");

  a_dir_follows: assert property (@(posedge clock_in) disable iff (rst_in)
    ##1 state_word_out[ESR_BIT_DIR] == $past(shaft_turn_left_in))
    else $error("direction bit stale");

  a_alarm_follows: assert property (@(posedge clock_in) disable iff (rst_in)
    ##1 state_word_out[ESR_BIT_ALARM] == $past(alarm_any_in))
    else $error("alarm bit stale");

  a_scale_follows: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(scale_en_in) |=> state_word_out[ESR_BIT_SCALE])
    else $error("scaling bit stale");
endmodule // esr_state_word
`default_nettype wire

// file: rtl/esr_reply.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Status bit 1 mirrors counting direction
// - Status bit 8 flags any active alarm
// - Remaining status bits carry no function
// - Status also readable as holding 98-99
// - Good servable request gets normal response
// - Lost or corrupt request gets no response
// - Unservable request gets exception response
// - Normal response echoes function code
// - Function code msb reserved for exceptions
// - Exception sets msb: code plus 80h
// - Exception carries one exception code
// - Code 01: unsupported function or state
// - Code 02: range beyond last register
// - Code 03: structurally malformed request
// - Code 04: internal failure during action
// - Code 05: long programming command accepted
// - Code 06: busy with previous command
// - Status bit 0 mirrors scaling enable
// - Input registers read-only via function 04
module esr_reply
  import esr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  // Live device settings
  input wire logic scale_en_in,
  input wire logic shaft_turn_left_in,
  input wire logic alarm_any_in,
  input wire logic configured_in,
  input wire logic internal_fault_in,
  input wire logic prog_busy_in,
  // Request from the transport side
  input wire logic req_valid_in,
  input wire logic req_comm_err_in,
  input wire logic req_len_err_in,
  input wire logic req_prog_cmd_in,
  input wire logic [7:0] req_func_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] req_qty_in,
  // Response toward the transport side
  output logic rsp_valid_out,
  output logic rsp_exception_out,
  output logic [7:0] rsp_func_out,
  output logic [7:0] rsp_exc_code_out,
  output logic [7:0] rsp_byte_count_out,
  output logic [31:0] rsp_data_out,
  output logic [31:0] state_word_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Status word

  logic [31:0] state_word;

  esr_state_word u_state_word (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .scale_en_in(scale_en_in),
    .shaft_turn_left_in(shaft_turn_left_in),
    .alarm_any_in(alarm_any_in),
    .state_word_out(state_word)
  );

  assign state_word_out = state_word;

  ////////////////////////////////////////////////////////////////////////////
  // Request decoding

  // End address of a read, widened so a wrap is seen as out of range
  function automatic logic [16:0] esr_end_addr(input logic [15:0] a, input logic [15:0] q);
    esr_end_addr = {1'b0, a} + {1'b0, q} - 17'h0_0001;
  endfunction

  // Register read: only the two status word halves exist here
  function automatic logic [15:0] esr_read_half(input logic [15:0] idx, input logic [15:0] base,
                                                input logic [31:0] word);
    if (idx == base)
      esr_read_half = word[31:16];
    else
      esr_read_half = word[15:0];
  endfunction

  typedef struct packed {
    logic valid;
    logic exception;
    logic [7:0] func;
    logic [7:0] exc_code;
    logic [7:0] byte_count;
    logic [31:0] data;
  } esr_rsp_s;

  esr_rsp_s rsp_reg;
  esr_rsp_s rsp_next;

  logic func_known;
  logic [15:0] base_idx;
  logic [15:0] last_idx;
  logic [16:0] end_idx;
  logic addr_ok;
  logic qty_ok;
  logic [7:0] exc_sel;
  logic [15:0] half_a;
  logic [15:0] half_b;

  always_comb
  begin
    func_known = 1'b0;
    base_idx = ESR_INPUT_STATE_IDX;
    last_idx = ESR_INPUT_LAST;
    if (req_func_in == ESR_FC_READ_INPUT)
    begin
      func_known = 1'b1;
      base_idx = ESR_INPUT_STATE_IDX;
      last_idx = ESR_INPUT_LAST;
    end
    else if (req_func_in == ESR_FC_READ_HOLD)
    begin
      func_known = 1'b1;
      base_idx = ESR_HOLD_STATE_IDX;
      last_idx = ESR_HOLD_LAST;
    end
  end

  // Quantity outside the legal span is a structural fault
  assign qty_ok = (req_qty_in >= ESR_QTY_MIN) && (req_qty_in <= ESR_QTY_MAX);
  assign end_idx = esr_end_addr(req_addr_in, req_qty_in);
  // Exactly ending on the last register is fine
  assign addr_ok = (req_addr_in >= base_idx) && (end_idx <= {1'b0, last_idx});

  // Priority follows the order a server would test: function, state, shape, address
  always_comb
  begin
    exc_sel = ESR_EX_NONE;
    if (!func_known || !configured_in || req_func_in[7])
      exc_sel = ESR_EX_ILL_FUNC;
    else if (req_len_err_in || !qty_ok)
      exc_sel = ESR_EX_ILL_VALUE;
    else if (!addr_ok)
      exc_sel = ESR_EX_ILL_ADDR;
    else if (prog_busy_in)
      exc_sel = ESR_EX_BUSY;
    else if (internal_fault_in)
      exc_sel = ESR_EX_DEV_FAIL;
    else if (req_prog_cmd_in)
      exc_sel = ESR_EX_ACK;
  end

  assign half_a = esr_read_half(req_addr_in, base_idx, state_word);
  assign half_b = esr_read_half(req_addr_in + 16'h0001, base_idx, state_word);

  ////////////////////////////////////////////////////////////////////////////
  // Response build

  always_comb
  begin
    rsp_next = '0;
    // Corrupted request is simply dropped; the client times out
    if (req_valid_in && !req_comm_err_in)
    begin
      rsp_next.valid = 1'b1;
      if (exc_sel != ESR_EX_NONE)
      begin
        rsp_next.exception = 1'b1;
        rsp_next.func = req_func_in | ESR_FC_EXC_FLAG;
        rsp_next.exc_code = exc_sel;
        rsp_next.byte_count = 8'h01;
        rsp_next.data = {24'h00_0000, exc_sel};
      end
      else
      begin
        rsp_next.func = req_func_in;
        rsp_next.byte_count = {req_qty_in[6:0], 1'b0};
        if (req_qty_in == ESR_QTY_MIN)
          rsp_next.data = {16'h0000, half_a};
        else
          rsp_next.data = {half_a, half_b};
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      rsp_reg <= '0;
    else
      rsp_reg <= rsp_next;
  end

  assign rsp_valid_out = rsp_reg.valid;
  assign rsp_exception_out = rsp_reg.exception;
  assign rsp_func_out = rsp_reg.func;
  assign rsp_exc_code_out = rsp_reg.exc_code;
  assign rsp_byte_count_out = rsp_reg.byte_count;
  assign rsp_data_out = rsp_reg.data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_no_reply_err: assert property (@(posedge clock_in) disable iff (rst_in)
    (!req_valid_in || req_comm_err_in) |=> !rsp_valid_out)
    else $error("response sent for bad request");

  a_reply_good: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in) |=> rsp_valid_out)
    else $error("good request not answered");

  a_echo_normal: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && !rsp_exception_out) |-> rsp_func_out == $past(req_func_in))
    else $error("function code not echoed");

  a_exc_msb_set: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && rsp_exception_out) |-> rsp_func_out == ($past(req_func_in) | 8'h80))
    else $error("exception msb wrong");

  a_exc_code_data: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && rsp_exception_out) |-> rsp_data_out[7:0] == rsp_exc_code_out && rsp_exc_code_out != 8'h00)
    else $error("exception code missing");

  a_unknown_func: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && req_func_in != 8'h03 && req_func_in != 8'h04)
    |=> rsp_exception_out && rsp_exc_code_out == 8'h01)
    else $error("unsupported function not code 01");

  a_addr_range: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && req_func_in == 8'h03 && !req_len_err_in
     && req_addr_in == 16'h0062 && req_qty_in == 16'h0003) |=> rsp_exc_code_out == 8'h02)
    else $error("range overrun not code 02");

  a_hold_mirror: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && req_func_in == 8'h03 && !req_len_err_in
     && !prog_busy_in && !internal_fault_in && !req_prog_cmd_in
     && req_addr_in == 16'h0062 && req_qty_in == 16'h0002) |=> rsp_data_out == $past(state_word))
    else $error("holding copy differs");

  a_busy_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && rsp_exc_code_out == 8'h06) |-> $past(prog_busy_in))
    else $error("busy code without busy");

  a_fail_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && rsp_exc_code_out == 8'h04) |-> $past(internal_fault_in))
    else $error("failure code without fault");

  a_msb_func_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && req_func_in[7])
    |=> rsp_exception_out && rsp_exc_code_out == ESR_EX_ILL_FUNC)
    else $error("reserved msb function not code 01");

  a_unconfig_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && !configured_in)
    |=> rsp_exception_out && rsp_exc_code_out == ESR_EX_ILL_FUNC)
    else $error("unconfigured read not code 01");

  a_len_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && req_len_err_in
     && (req_func_in == ESR_FC_READ_HOLD || req_func_in == ESR_FC_READ_INPUT))
    |=> rsp_exc_code_out == ESR_EX_ILL_VALUE)
    else $error("length fault not code 03");

  a_qty_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && (req_qty_in < ESR_QTY_MIN || req_qty_in > ESR_QTY_MAX)
     && (req_func_in == ESR_FC_READ_HOLD || req_func_in == ESR_FC_READ_INPUT))
    |=> rsp_exc_code_out == ESR_EX_ILL_VALUE)
    else $error("bad quantity not code 03");

  a_exact_end: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && !req_len_err_in && req_func_in == ESR_FC_READ_HOLD
     && req_addr_in == ESR_HOLD_LAST && req_qty_in == ESR_QTY_MIN)
    |=> rsp_valid_out && rsp_exc_code_out != ESR_EX_ILL_ADDR)
    else $error("read ending on last register refused");

  a_below_base: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && !req_len_err_in && req_func_in == ESR_FC_READ_HOLD
     && req_addr_in < ESR_HOLD_STATE_IDX && req_qty_in == ESR_QTY_MIN)
    |=> rsp_exc_code_out == ESR_EX_ILL_ADDR)
    else $error("missing register not code 02");

  a_input_overrun: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && !req_len_err_in && req_func_in == ESR_FC_READ_INPUT
     && req_addr_in == ESR_INPUT_LAST && req_qty_in == 16'h0002)
    |=> rsp_exc_code_out == ESR_EX_ILL_ADDR)
    else $error("input overrun not code 02");

  a_input_mirror: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && !req_len_err_in && req_func_in == ESR_FC_READ_INPUT
     && !prog_busy_in && !internal_fault_in && !req_prog_cmd_in
     && req_addr_in == ESR_INPUT_STATE_IDX && req_qty_in == 16'h0002)
    |=> rsp_data_out == $past(state_word))
    else $error("input copy differs");

  a_busy_answer: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && !req_len_err_in && req_func_in == ESR_FC_READ_HOLD
     && prog_busy_in && req_addr_in == ESR_HOLD_STATE_IDX && req_qty_in == 16'h0002)
    |=> rsp_exc_code_out == ESR_EX_BUSY)
    else $error("busy read not code 06");

  a_fault_answer: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && !req_len_err_in && req_func_in == ESR_FC_READ_HOLD
     && !prog_busy_in && internal_fault_in && req_addr_in == ESR_HOLD_STATE_IDX && req_qty_in == 16'h0002)
    |=> rsp_exc_code_out == ESR_EX_DEV_FAIL)
    else $error("faulted read not code 04");

  a_ack_answer: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && configured_in && !req_len_err_in && req_func_in == ESR_FC_READ_HOLD
     && !prog_busy_in && !internal_fault_in && req_prog_cmd_in
     && req_addr_in == ESR_HOLD_STATE_IDX && req_qty_in == 16'h0002)
    |=> rsp_exc_code_out == ESR_EX_ACK)
    else $error("programming command not code 05");

  a_ack_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && rsp_exc_code_out == ESR_EX_ACK) |-> $past(req_prog_cmd_in))
    else $error("acknowledge code without command");

  a_no_ack_plain: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_valid_in && !req_comm_err_in && !req_prog_cmd_in)
    |=> rsp_exc_code_out != ESR_EX_ACK)
    else $error("acknowledge code for plain read");

  a_exc_count: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && rsp_exception_out) |-> rsp_byte_count_out == 8'h01)
    else $error("exception byte count not one");

  a_normal_code: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && !rsp_exception_out) |-> rsp_exc_code_out == ESR_EX_NONE)
    else $error("normal reply carries exception code");

  a_normal_count: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && !rsp_exception_out) |-> {8'h00, rsp_byte_count_out} == 16'($past(req_qty_in) << 1))
    else $error("normal byte count wrong");

  a_qty1_data: assert property (@(posedge clock_in) disable iff (rst_in)
    (rsp_valid_out && !rsp_exception_out && $past(req_qty_in) == ESR_QTY_MIN) |-> rsp_data_out[31:16] == 16'h0000)
    else $error("single register reply has upper data");

  a_flag_msb: assert property (@(posedge clock_in) disable iff (rst_in)
    rsp_valid_out |-> rsp_exception_out == rsp_func_out[7])
    else $error("exception flag and function msb differ");

  a_idle_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    !rsp_valid_out |-> !rsp_exception_out && rsp_func_out == 8'h00 && rsp_exc_code_out == 8'h00
    && rsp_byte_count_out == 8'h00 && rsp_data_out == 32'h0000_0000)
    else $error("response fields set without valid");

  a_scale_tracks: assert property (@(posedge clock_in) disable iff (rst_in)
    ##1 state_word_out[ESR_BIT_SCALE] == $past(scale_en_in))
    else $error("scaling bit does not track");

  a_unused_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    state_word_out[31:9] == 23'h00_0000 && state_word_out[7:2] == 6'h00)
    else $error("unused status bits not zero at top");

  a_reset_clears: assert property (@(posedge clock_in)
    rst_in |=> !rsp_valid_out && state_word_out == ESR_STATE_RESET)
    else $error("outputs not cleared by reset");
endmodule // esr_reply
`default_nettype wire

// file: tb/esr_client_model.sv
`timescale 1ns/10ps
`default_nettype none
module esr_client_model
  import esr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rsp_valid_in,
  input wire logic [7:0] rsp_func_in,
  input wire logic [31:0] rsp_data_in,
  output logic req_valid_out,
  output logic req_comm_err_out,
  output logic req_len_err_out,
  output logic req_prog_cmd_out,
  output logic [7:0] req_func_out,
  output logic [15:0] req_addr_out,
  output logic [15:0] req_qty_out
);
  initial
  begin
    {req_valid_out, req_comm_err_out, req_len_err_out, req_prog_cmd_out} = 4'h0;
    {req_func_out, req_addr_out, req_qty_out} = 40'h00_0000_0000;
  end
  ////////////////////////////////////////////////////////////////
  // Flags are {comm error, length error, programming command}
  task automatic issue(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q, input logic [2:0] flags,
                       output logic got, output logic exc, output logic [7:0] code);
    int n;
    begin
      got = 1'b0;
      exc = 1'b0;
      code = 8'h00;
      n = 0;
      @(negedge clock_in);
      req_valid_out = 1'b1;
      {req_comm_err_out, req_len_err_out, req_prog_cmd_out} = flags;
      {req_func_out, req_addr_out, req_qty_out} = {f, a, q};
      @(negedge clock_in);
      req_valid_out = 1'b0;
      {req_comm_err_out, req_len_err_out, req_prog_cmd_out} = ~flags;
      // Released fields show junk, not the last request
      {req_func_out, req_addr_out, req_qty_out} = ~{f, a, q};
      // Lost requests end on a bounded wait
      while (n < 4 && got == 1'b0)
      begin
        if (rsp_valid_in === 1'b1)
          got = 1'b1;
        else
        begin
          @(negedge clock_in);
          n++;
        end
      end
      exc = got & rsp_func_in[7];
      code = exc ? rsp_data_in[7:0] : 8'h00;
    end
  endtask
endmodule // esr_client_model
`default_nettype wire

// file: tb/tb_esr_reply.sv
`timescale 1ns/10ps
`default_nettype none
module tb_esr_reply;
  import esr_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic scale_en = 1'b0, turn_left = 1'b0, alarm_any = 1'b0, configured = 1'b1, fault = 1'b0, busy = 1'b0;
  logic req_valid, req_comm_err, req_len_err, req_prog_cmd;
  logic [7:0] req_func;
  logic [15:0] req_addr, req_qty;
  logic rsp_valid, rsp_exc, got, exc;
  logic [7:0] rsp_func, rsp_exc_code, rsp_bc, code;
  logic [31:0] rsp_data, state_word, sw;
  int err_total = 0;
  int n_checks = 0;
  always #20 clock_in = ~clock_in;
  esr_reply esr_reply_inst (.clock_in(clock_in), .rst_in(rst_in), .scale_en_in(scale_en),
    .shaft_turn_left_in(turn_left), .alarm_any_in(alarm_any), .configured_in(configured),
    .internal_fault_in(fault), .prog_busy_in(busy), .req_valid_in(req_valid), .req_comm_err_in(req_comm_err),
    .req_len_err_in(req_len_err), .req_prog_cmd_in(req_prog_cmd), .req_func_in(req_func), .req_addr_in(req_addr),
    .req_qty_in(req_qty), .rsp_valid_out(rsp_valid), .rsp_exception_out(rsp_exc), .rsp_func_out(rsp_func),
    .rsp_exc_code_out(rsp_exc_code), .rsp_byte_count_out(rsp_bc), .rsp_data_out(rsp_data),
    .state_word_out(state_word));
  esr_client_model esr_client_model_inst (.clock_in(clock_in), .rsp_valid_in(rsp_valid), .rsp_func_in(rsp_func),
    .rsp_data_in(rsp_data), .req_valid_out(req_valid), .req_comm_err_out(req_comm_err),
    .req_len_err_out(req_len_err), .req_prog_cmd_out(req_prog_cmd), .req_func_out(req_func),
    .req_addr_out(req_addr), .req_qty_out(req_qty));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (exp !== seen)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic norm_case(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q, input logic [31:0] d);
    esr_client_model_inst.issue(f, a, q, 3'b000, got, exc, code);
    chk("answered", 32'h1, {31'h0, got});
    chk("exception flag", 32'h0, {31'h0, rsp_exc});
    chk("no exception code", 32'h0, {24'h0, rsp_exc_code});
    chk("function echo", {24'h0, f}, {24'h0, rsp_func});
    chk("byte count", {q[14:0], 1'b0}, {16'h0, rsp_bc});
    chk("read data", d, rsp_data);
  endtask
  task automatic exc_case(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q, input logic [2:0] fl,
                          input logic [7:0] e);
    esr_client_model_inst.issue(f, a, q, fl, got, exc, code);
    chk("exception seen", 32'h1, {31'h0, got & exc});
    chk("exception flag out", 32'h1, {31'h0, rsp_exc});
    chk("exception code field", {24'h0, e}, {24'h0, rsp_exc_code});
    chk("exception function", {24'h0, f | 8'h80}, {24'h0, rsp_func});
    chk("exception code", {24'h0, e}, {24'h0, code});
    chk("exception count", 32'h1, {24'h0, rsp_bc});
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #(2000 * 40);
    err_total++;
    close_out();
  end
  initial
  begin
    repeat (12) @(negedge clock_in);
    rst_in = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      // Direction comes only from turn_left, driven by loop bit i[1]
      {alarm_any, turn_left, scale_en} = i[2:0];
      sw = {23'h0, i[2], 6'h00, i[1], i[0]};
      @(negedge clock_in);
      chk("status word", sw, state_word);
      norm_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, sw);
      norm_case(ESR_FC_READ_INPUT, ESR_INPUT_STATE_IDX, 16'h0002, sw);
      norm_case(ESR_FC_READ_HOLD, ESR_HOLD_LAST, 16'h0001, {16'h0, sw[15:0]});
    end
    $display("test status and normal reads done");
    exc_case(8'h06, ESR_HOLD_STATE_IDX, 16'h0001, 3'b000, ESR_EX_ILL_FUNC);
    exc_case(8'h83, ESR_HOLD_STATE_IDX, 16'h0001, 3'b000, ESR_EX_ILL_FUNC);
    configured = 1'b0;
    exc_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, 3'b000, ESR_EX_ILL_FUNC);
    configured = 1'b1;
    exc_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, 3'b010, ESR_EX_ILL_VALUE);
    exc_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0000, 3'b000, ESR_EX_ILL_VALUE);
    exc_case(ESR_FC_READ_INPUT, ESR_INPUT_STATE_IDX, ESR_QTY_MAX + 16'h0001, 3'b000, ESR_EX_ILL_VALUE);
    exc_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0003, 3'b000, ESR_EX_ILL_ADDR);
    exc_case(ESR_FC_READ_INPUT, ESR_INPUT_LAST, 16'h0002, 3'b000, ESR_EX_ILL_ADDR);
    exc_case(ESR_FC_READ_HOLD, ESR_INPUT_STATE_IDX, 16'h0001, 3'b000, ESR_EX_ILL_ADDR);
    busy = 1'b1;
    exc_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, 3'b000, ESR_EX_BUSY);
    busy = 1'b0;
    fault = 1'b1;
    exc_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, 3'b000, ESR_EX_DEV_FAIL);
    fault = 1'b0;
    exc_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, 3'b001, ESR_EX_ACK);
    $display("test exception codes done");
    esr_client_model_inst.issue(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, 3'b100, got, exc, code);
    chk("dropped frame answered", 32'h0, {31'h0, got});
    norm_case(ESR_FC_READ_HOLD, ESR_HOLD_STATE_IDX, 16'h0002, sw);
    $display("test dropped frame done");
    close_out();
  end
endmodule // tb_esr_reply
`default_nettype wire
